// file: dhi_bridge.sv
// Disk DMA host interface: decode, control, data latches, DMA flow.
// Assumes host strobes already synchronous to clk; SASI lines likewise.
`timescale 1ns/1ps
module dhi_bridge (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [19:12] hostAddrHi, // Upper host address
	input wire logic [7:0] hostAdIn, // Multiplexed address/data bus in
	input wire logic hostIoNotMem, // I/O-versus-memory qualifier
	input wire logic hostAle, // Address latch strobe
	input wire logic hostRd_n, // Host read strobe
	input wire logic hostWr_n, // Host write strobe
	input wire logic [7:0] baseJumper, // Base address bits 19:12
	input wire logic holdAck, // Processor grants the bus
	input wire logic onboard_mem_latch_n, // Low-RAM read data strobe
	input wire logic [7:0] memDataIn, // Memory data during DMA read
	input wire logic sasiIoDir, // SASI I/O line, low = output
	input wire logic sasiCmdData, // SASI C/D line, high = data
	input wire logic controller_request, // SASI request, high active
	input wire logic [7:0] sasiData_n, // SASI data lines (inverted bus)
	output logic [7:0] hostAdOut, // Data toward host bus
	output logic hostAdOe, // Host bus driven by board
	output logic bufToHost, // Data buffer direction
	output logic external_io_override_n, // Open-collector override
	output logic extIoOe, // Override pull-down enable
	output logic [7:0] sasiDataOut_n, // SASI data out (inverted bus)
	output logic sasiDataOe, // SASI data driven
	output logic controller_select_n, // SASI select
	output logic sasiAck_n, // SASI acknowledge
	output logic hold, // Hold request to processor
	output logic [19:0] dmaAddr, // DMA memory address
	output logic dmaMemWr, // DMA cycle writes memory
	output logic dma_read_strobe_n, // Input latch drive strobe
	output logic write_select_group_a_n // Write select for data group
);
	import dhi_pkg::*;
	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Group select from latched A7:A5; A4 and low nibble never examined
	function automatic logic grpHit(input logic [3:0] a74, input logic [2:0] grp);
		grpHit = (a74[3:1] == {1'b1, grp[2:1]});
	endfunction
	// Unqualified selects use A7:A4 fully
	function automatic logic selHit(input logic [3:0] a74, input logic [3:0] s);
		selHit = (a74 == s);
	endfunction
	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr74; // Latched A7:A4
		logic [7:0] ctl; // Control register
		logic dmaOn; // Reset-conditioned DMA enable
		logic [7:0] outLatch; // Host-to-controller data, held inverted for the bus
		logic [7:0] inLatch; // Controller-to-host data
		logic reqPrev; // Request seen last cycle
		logic wrPrev; // Write strobe last cycle
		logic dlPrev; // Low-RAM strobe last cycle
		logic newReq; // Pending data request
		logic [19:0] addr; // Memory address counter
		dhi_phase_t phase; // DMA cycle phase
		logic [4:0] phCnt; // Cycles within phase
		logic [4:0] tout; // Phases since last request
		logic [4:0] toutCyc; // Cycles toward next phase tick
		logic ack; // Acknowledge pending
		logic sel; // Controller select
		logic selPulse; // Select pulse from register write
		logic [7:0] hostOut; // Host bus data
		logic hostOe; // Host bus drive
		logic toHost; // Buffer direction
		logic extIo; // Override active
		logic sasiOe; // SASI drive
		logic holdQ; // Hold request
		logic drd; // Read strobe active
		logic wsA; // Data group write select
	} dhi_st_t;
	dhi_st_t st_q, st_d;
	// FIFO between output latch source and the SASI driver
	dhi_fifo_if fq();
	dhi_fifo #(.WIDTH(8), .DEPTH(DHI_FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.port(fq.fifo)
	);
	// ------------------------------------------------------------
	// Combinational decode
	// ------------------------------------------------------------
	logic boardSel, wrAct, rdAct, wsData, wsCtl, wsAddr, rsData, rsStat;
	logic csLo, csHi, reqFall, wrEnd, dlFall, t4Fall, loadOut;
	logic [7:0] loadVal;
	// Base compare on upper bits plus I/O qualifier
	assign boardSel = (hostAddrHi == baseJumper) && !hostIoNotMem;
	assign wrAct = boardSel && !hostWr_n;
	assign rdAct = boardSel && !hostRd_n;
	assign wsData = wrAct && grpHit(st_q.addr74, DHI_GRP_DATA);
	assign wsCtl = wrAct && grpHit(st_q.addr74, DHI_GRP_CTRL);
	assign wsAddr = wrAct && grpHit(st_q.addr74, DHI_GRP_ADDR);
	assign rsData = rdAct && grpHit(st_q.addr74, DHI_GRP_DATA);
	assign rsStat = rdAct && grpHit(st_q.addr74, DHI_GRP_CTRL);
	// Unqualified selects load the address counter bytes
	assign csLo = wrAct && selHit(st_q.addr74, DHI_SEL_ADRLO | 4'hC);
	assign csHi = wrAct && selHit(st_q.addr74, DHI_SEL_ADRHI | 4'hC);
	assign reqFall = st_q.reqPrev && !controller_request;
	assign wrEnd = !st_q.wrPrev && hostWr_n;
	assign dlFall = st_q.dlPrev && !onboard_mem_latch_n;
	assign t4Fall = (st_q.phase == DHI_T3) && (st_q.phCnt == 5'(DHI_PHASE_CYC - 1));
	// Select the output latch strobe by cycle kind
	always_comb
	begin
		loadOut = 1'b0;
		loadVal = hostAdIn;
		if (st_q.phase != DHI_IDLE && !st_q.ctl[DHI_CTL_MEMWR])
		begin
			loadVal = memDataIn;
			loadOut = st_q.ctl[DHI_CTL_LORAM] ? dlFall : t4Fall;
		end
		else if (wrEnd && grpHit(st_q.addr74, DHI_GRP_DATA) && boardSel)
			loadOut = 1'b1;
	end
	assign fq.inData = loadVal;
	assign fq.inValid = loadOut;
	// Drain toward the SASI latch only while output direction holds
	assign fq.outReady = !sasiIoDir;
	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		st_d.reqPrev = controller_request;
		st_d.wrPrev = hostWr_n;
		st_d.dlPrev = onboard_mem_latch_n;
		st_d.selPulse = 1'b0;
		if (hostAle)
			st_d.addr74 = hostAdIn[7:4];
		// Write-only control register
		if (wsCtl)
		begin
			st_d.ctl = hostAdIn;
			st_d.dmaOn = hostAdIn[DHI_CTL_DMAEN];
			st_d.selPulse = hostAdIn[DHI_CTL_SELECT];
		end
		// Controller select follows enable, pulsed by writes
		st_d.sel = st_q.dmaOn || st_d.selPulse;
		// Address counter load and per-byte increment
		if (csLo)
			st_d.addr[7:0] = hostAdIn;
		if (csHi)
			st_d.addr[19:8] = {baseJumper[3:0], hostAdIn};
		if (fq.outValid && fq.outReady)
			st_d.outLatch = ~fq.outData;
		// Input latch at falling edge of the request
		if (reqFall)
			st_d.inLatch = ~sasiData_n;
		// Data-phase requests only, and only while DMA on
		if (controller_request && !st_q.reqPrev && sasiCmdData && st_q.dmaOn)
			st_d.newReq = 1'b1;
		// Hold request and timeout
		if (st_q.newReq)
			st_d.holdQ = 1'b1;
		st_d.toutCyc = (st_q.toutCyc == 5'(DHI_PHASE_CYC - 1)) ? '0 : st_q.toutCyc + 1'b1;
		if (controller_request)
			st_d.tout = '0;
		else if (st_q.toutCyc == 5'(DHI_PHASE_CYC - 1) && st_q.tout != 5'(DHI_TOUT_PHASES))
			st_d.tout = st_q.tout + 1'b1;
		// Clear first so a new acknowledge in the same cycle wins
		if (st_q.ack && !controller_request)
			st_d.ack = 1'b0;
		// DMA cycle phases
		st_d.phCnt = (st_q.phCnt == 5'(DHI_PHASE_CYC - 1)) ? '0 : st_q.phCnt + 1'b1;
		case (st_q.phase)
			DHI_IDLE:
			begin
				st_d.phCnt = '0;
				if (st_q.newReq && st_q.holdQ && holdAck)
					st_d.phase = DHI_T1;
			end
			DHI_T1:
				if (st_q.phCnt == 5'(DHI_PHASE_CYC - 1))
					st_d.phase = DHI_T2;
			DHI_T2:
			begin
				st_d.newReq = 1'b0;
				if (st_q.phCnt == 5'(DHI_PHASE_CYC - 1))
					st_d.phase = DHI_T3;
			end
			DHI_T3:
				if (st_q.phCnt == 5'(DHI_PHASE_CYC - 1))
					st_d.phase = DHI_T4;
			DHI_T4:
				if (st_q.phCnt == 5'(DHI_PHASE_CYC - 1))
					st_d.phase = DHI_T5;
			DHI_T5:
			begin
				st_d.phase = DHI_IDLE;
				st_d.addr = st_q.addr + 20'h00001;
				st_d.ack = 1'b1;
			end
			default:
				st_d.phase = DHI_IDLE;
		endcase
		// Host-side byte moves also acknowledge
		if (rsData || wrEnd && grpHit(st_q.addr74, DHI_GRP_DATA) && boardSel)
			st_d.ack = 1'b1;
		// Release on completion or timeout
		if (st_q.phase == DHI_T5 && !st_q.newReq || st_q.tout == 5'(DHI_TOUT_PHASES))
			st_d.holdQ = 1'b0;
		// Read strobe: T2 of memory write or CPU read of data
		st_d.drd = (st_d.phase == DHI_T2 && st_q.ctl[DHI_CTL_MEMWR]) || rsData;
		// Host bus drive and direction
		st_d.toHost = rdAct || st_d.drd;
		st_d.hostOe = st_d.drd || rsStat;
		st_d.hostOut = rsStat ? {3'h0, sasiIoDir, sasiCmdData, controller_request,
			st_q.holdQ, st_q.dmaOn} : st_q.inLatch;
		st_d.extIo = boardSel;
		st_d.sasiOe = !sasiIoDir;
		st_d.wsA = wsData;
		// System reset clears the enable whatever was latched
		if (!st_q.dmaOn)
		begin
			st_d.newReq = 1'b0;
			st_d.holdQ = st_q.holdQ && st_q.phase != DHI_IDLE;
		end
	end
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_q <= '0;
			st_q.ctl <= DHI_CTL_RESET;
			st_q.reqPrev <= 1'b0;
			st_q.wrPrev <= 1'b1;
			st_q.dlPrev <= 1'b1;
			st_q.phase <= DHI_IDLE;
		end
		else
			st_q <= st_d;
	end
	// ------------------------------------------------------------
	// Outputs from the state record, except the override level tied low
	// ------------------------------------------------------------
	assign hostAdOut = st_q.hostOut;
	assign hostAdOe = st_q.hostOe;
	assign bufToHost = st_q.toHost;
	assign external_io_override_n = 1'b0;
	assign extIoOe = st_q.extIo;
	assign sasiDataOut_n = st_q.outLatch;
	assign sasiDataOe = st_q.sasiOe;
	assign controller_select_n = !st_q.sel;
	assign sasiAck_n = !st_q.ack;
	assign hold = st_q.holdQ;
	assign dmaAddr = st_q.addr;
	assign dmaMemWr = st_q.ctl[DHI_CTL_MEMWR];
	assign dma_read_strobe_n = !st_q.drd;
	assign write_select_group_a_n = !st_q.wsA;
endmodule

// file: dhi_bridge_assertions.sv
// Port-level checker for the disk DMA host interface bridge.
// Assumes it is bound onto dhi_bridge and that all ports share clk.
`timescale 1ns/1ps
module dhi_bridge_assertions (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [19:12] hostAddrHi,
	input wire logic [7:0] baseJumper,
	input wire logic hostRd_n,
	input wire logic hostWr_n,
	input wire logic sasiIoDir,
	input wire logic controller_request,
	input wire logic hostAdOe,
	input wire logic bufToHost,
	input wire logic extIoOe,
	input wire logic sasiDataOe,
	input wire logic controller_select_n,
	input wire logic hold,
	input wire logic [19:0] dmaAddr,
	input wire logic dma_read_strobe_n,
	input wire logic write_select_group_a_n
);
	// ----------------
	// Idle hold counter
	// ----------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic [9:0] idleCnt_q; // Held bus with no request pending
	logic [9:0] idleCnt_d;
	// Runs only while the bus is held idle; any request restarts it
	always_comb
	begin
		idleCnt_d = 10'h000;
		if (hold && !controller_request)
			idleCnt_d = idleCnt_q + 10'h001;
	end
	// Cleared in reset like the design
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			idleCnt_q <= 10'h000;
		else
			idleCnt_q <= idleCnt_d;
	end
	// ----------------
	// Assertions
	// ----------------
	a_reset_quiet: assert property (!$past(rst_n) |-> !hold && controller_select_n)
		else $error("hold or select active after reset");
	a_override_match: assert property (extIoOe |-> $past(hostAddrHi) == $past(baseJumper))
		else $error("override without board address");
	a_sasi_dir: assert property (sasiDataOe |-> !$past(sasiIoDir))
		else $error("SASI data driven in input direction");
	a_read_release: assert property (hostAdOe |-> bufToHost && (hold || !$past(hostRd_n)))
		else $error("host bus driven outside a read");
	a_ws_strobe: assert property (!write_select_group_a_n |-> !$past(hostWr_n))
		else $error("write select without write strobe");
	a_drd_dir: assert property (!dma_read_strobe_n |-> bufToHost)
		else $error("input latch drives with buffer toward board");
	a_addr_step: assert property ($changed(dmaAddr) && $past(rst_n) && $past(hostWr_n)
		&& $past(hostWr_n, 2) |-> dmaAddr == $past(dmaAddr) + 20'h00001)
		else $error("address moved by other than one");
	a_hold_cause: assert property ($rose(hold) |-> $past(controller_request))
		else $error("hold raised without controller request");
	a_hold_bound: assert property (idleCnt_q < 10'h1B8)
		else $error("hold kept long after last request");
endmodule

// file: dhi_bridge_test.sv
// Self-checking bench for the disk DMA host interface bridge.
// Assumes dhi_pkg, the bridge with its FIFO, the checker and the model.
`timescale 1ns/1ps
module dhi_bridge_test;
	import dhi_pkg::*;
	// ----------------
	// Signals
	// ----------------
	logic clk, rst_n, hostAle, hostRd_n, hostWr_n, holdAck;
	logic [7:0] hostAddrHi, hostAdIn, memDataIn, hostAdOut, sasiDataOut_n, sasiData_n;
	logic hostAdOe, bufToHost, external_io_override_n, extIoOe, sasiDataOe, hold, sasiAck_n;
	logic controller_select_n, dmaMemWr, dma_read_strobe_n, write_select_group_a_n;
	logic sasiIoDir, sasiCmdData, controller_request;
	logic [19:0] dmaAddr;
	logic [7:0] seenRd; // Sampled inside a host cycle
	logic seenOe, seenWs, seenDrv;
	int num_errors = 0;
	int n_compared = 0;
	int selSeen = 0; // Cycles with select low
	int holdSeen = 0;
	int ackSeen = 0;
	dhi_bridge u_dut (.clk, .rst_n, .hostAddrHi, .hostAdIn, .hostIoNotMem(1'b0), .hostAle,
		.hostRd_n, .hostWr_n, .baseJumper(DHI_BASE_HI), .holdAck, .onboard_mem_latch_n(1'b1),
		.memDataIn, .sasiIoDir, .sasiCmdData, .controller_request, .sasiData_n, .hostAdOut,
		.hostAdOe, .bufToHost, .external_io_override_n, .extIoOe, .sasiDataOut_n, .sasiDataOe,
		.controller_select_n, .sasiAck_n, .hold, .dmaAddr, .dmaMemWr, .dma_read_strobe_n,
		.write_select_group_a_n);
	dhi_sasi_model u_ctrl (.clk, .sasiAck_n, .controller_request, .sasiData_n, .sasiIoDir,
		.sasiCmdData);
	always #4 clk = ~clk;
	// Grant follows hold; cycle counters; memory data kept moving
	always @(posedge clk)
	begin
		holdAck <= hold;
		memDataIn <= 8'($urandom);
		selSeen += (controller_select_n === 1'b0);
		holdSeen += (hold === 1'b1);
		ackSeen += (sasiAck_n === 1'b0);
	end
	// ----------------
	// Tasks
	// ----------------
	function automatic logic [7:0] statusOf(input logic io, input logic cd, input logic on);
		return {3'h0, io, cd, 2'h0, on};
	endfunction
	task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Address phase, then strobe held three edges; samples answers after two
	task automatic access(input logic [7:0] hi, input logic [3:0] grp, input logic wr,
		input logic [7:0] d);
		@(posedge clk);
		hostAddrHi <= hi;
		hostAdIn <= {grp, 4'($urandom)};
		hostAle <= 1'b1;
		@(posedge clk);
		hostAle <= 1'b0;
		hostAdIn <= d;
		hostWr_n <= !wr;
		hostRd_n <= wr;
		repeat (2) @(posedge clk);
		#1;
		seenOe = extIoOe;
		seenWs = write_select_group_a_n;
		seenDrv = hostAdOe;
		seenRd = hostAdOut;
		@(posedge clk);
		hostWr_n <= 1'b1;
		hostRd_n <= 1'b1;
		// Address stays one more edge so the strobe end still sees the board
		@(posedge clk);
		hostAddrHi <= 8'h00;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Watchdog, far beyond the expected run
	initial
	begin
		#400000;
		num_errors++;
		$display("Error watchdog expected end seen timeout");
		end_of_test();
	end
	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		logic [7:0] b;
		logic [19:0] start;
		int hc;
		int ac;
		clk = 1'b0;
		rst_n = 1'b0;
		hostAle = 1'b0;
		hostRd_n = 1'b1;
		hostWr_n = 1'b1;
		holdAck = 1'b0;
		hostAddrHi = 8'h00;
		hostAdIn = 8'h00;
		memDataIn = 8'h00;
		void'($urandom(32'hA6AC));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check("hold", 20'h0, hold);
		check("outEnables", 20'h1, {hostAdOe, sasiDataOe, extIoOe, controller_select_n});
		check("extIoLevel", 20'h0, external_io_override_n);
		check("bufDir", 20'h0, {bufToHost, !dma_read_strobe_n});
		$display("Test reset done");
		// Latch waits while direction is input, then drives
		b = 8'($urandom);
		access(DHI_BASE_HI, 4'h8, 1'b1, b);
		check("sasiOeIn", 20'h0, sasiDataOe);
		u_ctrl.phase(1'b0, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		check("sasiOut", {12'h001, ~b}, {sasiDataOe, sasiDataOut_n});
		// Both group halves, any low nibble
		for (int g = 8; g < 10; g++)
		begin
			b = 8'($urandom);
			access(DHI_BASE_HI, 4'(g), 1'b1, b);
			check("override", 20'h1, seenOe);
			check("wsGroupA", 20'h0, seenWs);
			check("sasiOut", {12'h000, ~b}, sasiDataOut_n);
		end
		access(8'hEE, 4'h8, 1'b1, 8'h00);
		check("foreignBase", 20'h1, {seenOe, seenWs});
		access(DHI_BASE_HI, 4'h8, 1'b0, 8'h00);
		check("wsOnRead", 20'h1, seenWs);
		access(DHI_BASE_HI, 4'hA, 1'b0, 8'h00);
		check("status", {12'h001, statusOf(1'b0, 1'b0, 1'b0)}, {seenDrv, seenRd});
		access(DHI_BASE_HI, 4'hD, 1'b0, 8'h00);
		check("wrOnlyRead", 20'h0, seenDrv);
		access(DHI_BASE_HI, 4'hF, 1'b0, 8'h00);
		check("unusedRead", 20'h0, seenDrv);
		$display("Test decode done");
		// Byte from the controller with DMA off, read by the host
		b = 8'($urandom);
		u_ctrl.phase(1'b1, 1'b1);
		u_ctrl.send(b, 4);
		access(DHI_BASE_HI, 4'h8, 1'b0, 8'h00);
		check("dataIn", {12'h001, b}, {seenDrv, seenRd});
		hc = selSeen;
		access(DHI_BASE_HI, 4'hA, 1'b1, 8'h02);
		check("selectPulse", 20'h1, 20'(selSeen > hc));
		$display("Test host data done");
		// Direction first, then start address, then enable
		access(DHI_BASE_HI, 4'hA, 1'b1, 8'h04);
		check("memWrDir", 20'h1, dmaMemWr);
		access(DHI_BASE_HI, 4'hD, 1'b1, 8'h34);
		access(DHI_BASE_HI, 4'hE, 1'b1, 8'h12);
		access(DHI_BASE_HI, 4'hA, 1'b1, 8'h05);
		check("addrLoad", 20'h01234, {4'h0, dmaAddr[15:0]});
		for (int i = 0; i < 4; i++)
		begin
			start = dmaAddr;
			hc = holdSeen;
			ac = ackSeen;
			repeat ($urandom_range(0, 20)) @(posedge clk);
			u_ctrl.send(8'($urandom), 600);
			repeat (3) @(posedge clk);
			#1;
			check("addrStep", start + 20'h00001, dmaAddr);
			check("holdAndAck", 20'h3, {19'(holdSeen > hc), ackSeen > ac});
		end
		repeat (450) @(posedge clk);
		#1;
		check("holdRelease", 20'h0, hold);
		$display("Test dma done");
		// Reset mid-run clears the control register, so DMA stays off
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		hc = holdSeen;
		u_ctrl.send(8'($urandom), 60);
		check("holdAfterReset", 20'h0, 20'(holdSeen - hc));
		$display("Test reset in run done");
		end_of_test();
	end
endmodule
bind dhi_bridge dhi_bridge_assertions u_chk (.clk, .rst_n, .hostAddrHi, .baseJumper, .hostRd_n,
	.hostWr_n, .sasiIoDir, .controller_request, .hostAdOe, .bufToHost, .extIoOe, .sasiDataOe,
	.controller_select_n, .hold, .dmaAddr, .dma_read_strobe_n, .write_select_group_a_n);

// file: dhi_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/1ps
module dhi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	dhi_fifo_if.fifo port
);
	import dhi_pkg::*;
	localparam int AW = $clog2(DEPTH);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
		logic [AW-1:0] wrPtr; // Write index
		logic [AW-1:0] rdPtr; // Read index
		logic [AW:0] count; // Words held
	} dhi_fifo_st_t;
	dhi_fifo_st_t st_q, st_d;
	logic push, pop;
	// Honest flags straight from the count
	assign port.inReady = (st_q.count != (AW+1)'(DEPTH));
	assign port.outValid = (st_q.count != '0);
	assign port.outData = st_q.mem[st_q.rdPtr];
	assign push = port.inValid && port.inReady;
	assign pop = port.outValid && port.outReady;
	// Next state
	always_comb
	begin
		st_d = st_q;
		if (push)
		begin
			st_d.mem[st_q.wrPtr] = port.inData;
			st_d.wrPtr = (st_q.wrPtr == AW'(DEPTH-1)) ? '0 : st_q.wrPtr + 1'b1;
		end
		if (pop)
			st_d.rdPtr = (st_q.rdPtr == AW'(DEPTH-1)) ? '0 : st_q.rdPtr + 1'b1;
		if (push && !pop)
			st_d.count = st_q.count + 1'b1;
		else if (pop && !push)
			st_d.count = st_q.count - 1'b1;
	end
	// Register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule

// file: dhi_fifo_if.sv
// Handshake carrier between the main block and its data FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface dhi_fifo_if;
	logic [7:0] inData; // Word toward FIFO
	logic inValid; // Writer offers a word
	logic inReady; // FIFO has room
	logic [7:0] outData; // Word from FIFO
	logic outValid; // FIFO holds a word
	logic outReady; // Reader takes the word
	modport fifo (input inData, input inValid, output inReady,
		output outData, output outValid, input outReady);
	modport user (output inData, output inValid, input inReady,
		input outData, input outValid, output outReady);
endinterface

// file: dhi_pkg.sv
// Constants and types for the disk DMA host interface block.
// Assumes a single 125 MHz clock and synchronous active-low reset.
package dhi_pkg;
	// ------------------------------------------------------------
	// Address decoding
	// ------------------------------------------------------------
	localparam logic [7:0] DHI_BASE_HI = 8'hEF; // Default jumper base, address bits 19:12
	localparam logic [3:0] DHI_BASE_MID = 4'h3; // Address bits 11:8 of default base
	localparam logic [2:0] DHI_GRP_DATA = 3'h0; // Group 80/81: SASI data
	localparam logic [2:0] DHI_GRP_CTRL = 3'h2; // Group A0/A1: control register
	localparam logic [2:0] DHI_GRP_ADDR = 3'h4; // Group C0/C1: address register
	localparam logic [3:0] DHI_SEL_STAT = 4'h0; // Unqualified select: status read
	localparam logic [3:0] DHI_SEL_ADRLO = 4'h1; // Unqualified select: address low
	localparam logic [3:0] DHI_SEL_ADRHI = 4'h2; // Unqualified select: address high
	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int DHI_CTL_DMAEN = 0; // DMA enable
	localparam int DHI_CTL_SELECT = 1; // Controller select
	localparam int DHI_CTL_MEMWR = 2; // Direction: 1 = memory write
	localparam int DHI_CTL_LORAM = 3; // Transfers use on-board memory
	localparam logic [7:0] DHI_CTL_RESET = 8'h00; // Control register reset value
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int DHI_PHASE_NS = 200; // Length of one DMA phase
	localparam int DHI_CLK_NS = 8; // Clock period
	localparam int DHI_PHASE_CYC = DHI_PHASE_NS / DHI_CLK_NS; // Cycles per phase
	localparam int DHI_TOUT_PHASES = 16; // Phases without request before release
	localparam int DHI_FIFO_DEPTH = 8; // Words held between host and controller
	// DMA cycle phases
	typedef enum logic [2:0] {DHI_IDLE, DHI_T1, DHI_T2, DHI_T3, DHI_T4, DHI_T5} dhi_phase_t;
endpackage

// file: dhi_sasi_model.sv
// Behavioural disk controller on the SASI side of the bridge.
// Assumes the bench calls its tasks; lines change just after clk rises.
`timescale 1ns/1ps
module dhi_sasi_model (
	input wire logic clk,
	input wire logic sasiAck_n,
	output logic controller_request,
	output logic [7:0] sasiData_n,
	output logic sasiIoDir,
	output logic sasiCmdData
);
	// Idle: no request, input direction, command phase
	initial
	begin
		controller_request = 1'b0;
		sasiData_n = 8'h5A;
		sasiIoDir = 1'b1;
		sasiCmdData = 1'b0;
	end
	// Direction and phase lines
	task automatic phase(input logic io, input logic cd);
		@(posedge clk);
		sasiIoDir <= io;
		sasiCmdData <= cd;
	endtask
	// One byte toward the host; waits for acknowledge up to len cycles
	task automatic send(input logic [7:0] b, input int len);
		int n;
		n = 0;
		@(posedge clk);
		sasiData_n <= ~b;
		controller_request <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (sasiAck_n !== 1'b0 && n < len);
		controller_request <= 1'b0;
		@(posedge clk);
		// Released bus shows the inverse, never a stale copy
		sasiData_n <= b;
	endtask
endmodule
